/* verilog/tcic_timer.sv */
// 16-bit timer counter core with input capture, apb register slave
// assumes trigger inputs asynchronous to clk, timer tick enables from an
// outside prescaler, and an interrupt controller that acknowledges
`timescale 1ns/1ps
`default_nettype none

module tcic_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] tick_in,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic capture_irq_ack,
  input wire logic overflow_irq_ack,
  output logic capture_irq,
  output logic overflow_irq,
  output logic [15:0] count_value,
  output logic count_top,
  output logic count_bottom
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] holder_q;
  logic [15:0] cnt_q;
  logic [15:0] cap_q;
  logic [15:0] oca_q;
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] cmp_cs_q;
  logic [1:0] mask_q;
  logic ovf_q;
  logic capf_q;
  logic down_q;
  logic [31:0] rdata_q;

  // apb decode; the slave always answers in the access cycle
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  // a low read takes its holder snapshot at the setup edge, the edge that also
  // latches the read data, so a tick between the two bus phases cannot tear a word
  assign rd = psel && !penable && !pwrite;
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = rdata_q;

  logic [2:0] clock_select_field;
  logic [3:0] waveform_mode_field;
  logic noise_filter_enable;
  logic edge_rising;
  logic comparator_trigger_select;
  assign clock_select_field = ctrl_b_q[tcic_pkg::CS_LSB +: 3];
  assign waveform_mode_field = {ctrl_b_q[tcic_pkg::MODE_HI_LSB +: 2],
                                ctrl_a_q[tcic_pkg::MODE_LO_LSB +: 2]};
  assign noise_filter_enable = ctrl_b_q[tcic_pkg::FILT_BIT];
  assign edge_rising = ctrl_b_q[tcic_pkg::EDGE_BIT];
  assign comparator_trigger_select = cmp_cs_q[tcic_pkg::CMP_SEL_BIT];

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  logic [15:0] top_val;
  logic cap_is_top;
  logic updown;
  logic ctc;
  always_comb begin
    top_val = tcic_pkg::TOP_MAX;
    cap_is_top = 1'b0;
    updown = 1'b0;
    ctc = 1'b0;
    unique case (waveform_mode_field)
      4'h1, 4'h5: top_val = tcic_pkg::TOP_8BIT;
      4'h2, 4'h6: top_val = tcic_pkg::TOP_9BIT;
      4'h3, 4'h7: top_val = tcic_pkg::TOP_10BIT;
      4'h4: begin
        top_val = oca_q;
        ctc = 1'b1;
      end
      4'h8, 4'ha: begin
        top_val = cap_q;
        cap_is_top = 1'b1;
      end
      4'h9, 4'hb: top_val = oca_q;
      4'hc: begin
        top_val = cap_q;
        cap_is_top = 1'b1;
        ctc = 1'b1;
      end
      4'he: begin
        top_val = cap_q;
        cap_is_top = 1'b1;
      end
      4'hf: top_val = oca_q;
      default: top_val = tcic_pkg::TOP_MAX;
    endcase
    updown = (waveform_mode_field inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
  end

  ////////////////////////////////////////////////////////////////////////
  // timer tick selection
  logic timer_tick;
  assign timer_tick = (clock_select_field != 3'h0) && tick_in[clock_select_field];

  assign count_top = (cnt_q == top_val);
  assign count_bottom = (cnt_q == tcic_pkg::RST_WORD);
  assign count_value = cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // holder register shared by all 16-bit registers
  // single shared holder
  always_ff @(posedge clk) begin
    if (rst) begin
      holder_q <= tcic_pkg::RST_BYTE;
    end else if (wr && (paddr == tcic_pkg::ADDR_CNT_HI || paddr == tcic_pkg::ADDR_CAP_HI ||
                        paddr == tcic_pkg::ADDR_OCA_HI)) begin
      holder_q <= wbyte;
    end else if (rd && paddr == tcic_pkg::ADDR_CNT_LO) begin
      holder_q <= cnt_q[15:8];
    end else if (rd && paddr == tcic_pkg::ADDR_CAP_LO) begin
      holder_q <= cap_q[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter; works whether or not ticks arrive
  logic cnt_wr;
  assign cnt_wr = wr && paddr == tcic_pkg::ADDR_CNT_LO;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= tcic_pkg::RST_WORD;
      down_q <= 1'b0;
    end else if (cnt_wr) begin
      cnt_q <= {holder_q, wbyte};
    end else if (timer_tick) begin
      if (updown) begin
        if (!down_q && cnt_q >= top_val) begin
          down_q <= 1'b1;
          cnt_q <= cnt_q - 16'h0001;
        end else if (down_q && count_bottom) begin
          down_q <= 1'b0;
          cnt_q <= cnt_q + 16'h0001;
        end else if (down_q) begin
          cnt_q <= cnt_q - 16'h0001;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end else if (count_top && waveform_mode_field != 4'h0) begin
        cnt_q <= tcic_pkg::RST_WORD;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  logic ovf_set;
  always_comb begin
    if (!timer_tick || cnt_wr) begin
      ovf_set = 1'b0;
    end else if (updown) begin
      ovf_set = down_q && count_bottom;
    end else if (ctc || waveform_mode_field == 4'h0) begin
      ovf_set = (cnt_q == tcic_pkg::TOP_MAX);
    end else begin
      ovf_set = count_top;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger path: select, filter, edge detect
  logic trig_raw;
  logic [1:0] sync_q;
  logic [tcic_pkg::FILT_LEN-2:0] filt_sh_q;
  logic [tcic_pkg::FILT_LEN-1:0] filt_win;
  logic filt_q;
  logic det_in;
  logic det_prev_q;
  logic cap_evt;
  // pin driven from port still enters here
  assign trig_raw = comparator_trigger_select ? comparator_output : capture_pin;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_q <= 2'b00;
    end else begin
      sync_q <= {sync_q[0], trig_raw};
    end
  end

  // the window is the stored samples plus the arriving one, so a clean change
  // reaches the edge detector four cycles later than with the filter off
  assign filt_win = {filt_sh_q, sync_q[1]};

  always_ff @(posedge clk) begin
    if (rst) begin
      filt_sh_q <= '0;
      filt_q <= 1'b0;
    end else if (!cap_is_top) begin
      filt_sh_q <= filt_win[tcic_pkg::FILT_LEN-2:0];
      if (&filt_win) begin
        filt_q <= 1'b1;
      end else if (~|filt_win) begin
        filt_q <= 1'b0;
      end
    end
  end

  assign det_in = noise_filter_enable ? filt_q : sync_q[1];

  always_ff @(posedge clk) begin
    if (rst) begin
      det_prev_q <= 1'b0;
    end else if (!cap_is_top) begin
      det_prev_q <= det_in;
    end
  end

  assign cap_evt = !cap_is_top && (edge_rising ? (det_in && !det_prev_q)
                                               : (!det_in && det_prev_q));

  ////////////////////////////////////////////////////////////////////////
  // capture register
  always_ff @(posedge clk) begin
    if (rst) begin
      cap_q <= tcic_pkg::RST_WORD;
    end else if (cap_evt) begin
      cap_q <= cnt_q;
    end else if (wr && paddr == tcic_pkg::ADDR_CAP_LO && cap_is_top) begin
      cap_q <= {holder_q, wbyte};
    end
  end

  // compare a register, used as top in some modes
  always_ff @(posedge clk) begin
    if (rst) begin
      oca_q <= tcic_pkg::RST_WORD;
    end else if (wr && paddr == tcic_pkg::ADDR_OCA_LO) begin
      oca_q <= {holder_q, wbyte};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_a_q <= tcic_pkg::RST_BYTE;
      ctrl_b_q <= tcic_pkg::RST_BYTE;
      cmp_cs_q <= tcic_pkg::RST_BYTE;
      mask_q <= 2'b00;
    end else if (wr) begin
      if (paddr == tcic_pkg::ADDR_CTRL_A) begin
        ctrl_a_q <= wbyte;
      end
      if (paddr == tcic_pkg::ADDR_CTRL_B) begin
        ctrl_b_q <= wbyte;
      end
      if (paddr == tcic_pkg::ADDR_CMP_CS) begin
        cmp_cs_q <= wbyte;
      end
      if (paddr == tcic_pkg::ADDR_MASK) begin
        mask_q <= wbyte[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags: set beats clear
  logic flag_wr;
  assign flag_wr = wr && paddr == tcic_pkg::ADDR_FLAGS;
  // clear by ack or write one
  always_ff @(posedge clk) begin
    if (rst) begin
      capf_q <= 1'b0;
    end else if (cap_evt) begin
      capf_q <= 1'b1;
    end else if (capture_irq_ack || (flag_wr && wbyte[tcic_pkg::CAP_BIT])) begin
      capf_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_q <= 1'b0;
    end else if (ovf_set) begin
      ovf_q <= 1'b1;
    end else if (overflow_irq_ack || (flag_wr && wbyte[tcic_pkg::OVF_BIT])) begin
      ovf_q <= 1'b0;
    end
  end

  assign capture_irq = capf_q && mask_q[tcic_pkg::CAP_BIT];
  assign overflow_irq = ovf_q && mask_q[tcic_pkg::OVF_BIT];

  ////////////////////////////////////////////////////////////////////////
  // read data, registered at the setup edge
  logic [7:0] rsel;
  always_comb begin
    unique case (paddr)
      tcic_pkg::ADDR_CNT_LO: rsel = cnt_q[7:0];
      tcic_pkg::ADDR_CAP_LO: rsel = cap_q[7:0];
      tcic_pkg::ADDR_OCA_LO: rsel = oca_q[7:0];
      tcic_pkg::ADDR_OCA_HI: rsel = oca_q[15:8];
      tcic_pkg::ADDR_CNT_HI, tcic_pkg::ADDR_CAP_HI: rsel = holder_q;
      tcic_pkg::ADDR_CTRL_A: rsel = ctrl_a_q;
      tcic_pkg::ADDR_CTRL_B: rsel = ctrl_b_q;
      tcic_pkg::ADDR_CMP_CS: rsel = cmp_cs_q;
      tcic_pkg::ADDR_FLAGS: rsel = {6'h00, capf_q, ovf_q};
      tcic_pkg::ADDR_MASK: rsel = {6'h00, mask_q};
      default: rsel = 8'h00;
    endcase
  end

  // prdata is the value latched in this read's setup phase; see note for timing
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      rdata_q <= {24'h000000, rsel};
    end
  end

endmodule

`default_nettype wire

/* verilog/tcic_pkg.sv */
// package for the 16-bit timer counter and input capture block
// assumes an apb slave with 32-bit data, one register per aligned word
package tcic_pkg;
  // register byte offsets
  localparam logic [11:0] ADDR_CNT_LO = 12'h000;
  localparam logic [11:0] ADDR_CNT_HI = 12'h004;
  localparam logic [11:0] ADDR_CAP_LO = 12'h008;
  localparam logic [11:0] ADDR_CAP_HI = 12'h00c;
  localparam logic [11:0] ADDR_OCA_LO = 12'h010;
  localparam logic [11:0] ADDR_OCA_HI = 12'h014;
  localparam logic [11:0] ADDR_CTRL_A = 12'h018;
  localparam logic [11:0] ADDR_CTRL_B = 12'h01c;
  localparam logic [11:0] ADDR_FLAGS = 12'h020;
  localparam logic [11:0] ADDR_MASK = 12'h024;
  localparam logic [11:0] ADDR_CMP_CS = 12'h028;
  // control b fields
  localparam int CS_LSB = 0;
  localparam int MODE_HI_LSB = 3;
  localparam int EDGE_BIT = 6;
  localparam int FILT_BIT = 7;
  // control a field: low two mode bits
  localparam int MODE_LO_LSB = 0;
  // flag and mask bits
  localparam int OVF_BIT = 0;
  localparam int CAP_BIT = 1;
  // comparator control: trigger select bit
  localparam int CMP_SEL_BIT = 0;
  // fixed tops
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] TOP_MAX = 16'hffff;
  // filter length in samples
  localparam int FILT_LEN = 4;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
endpackage

/* bench/tcic_timer_properties.sv */
// checker: port level properties of the timer block
// bound onto tcic_timer; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module tcic_timer_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [7:0] tick_in,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic capture_irq_ack,
  input wire logic overflow_irq_ack,
  input wire logic capture_irq,
  input wire logic overflow_irq,
  input wire logic [15:0] count_value,
  input wire logic count_bottom
);
  logic wr_acc;
  logic cnt_wr;
  logic [7:0] wr_byte;
  logic pin_q;
  logic cmp_q;
  logic [3:0] quiet_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign wr_acc = psel && penable && pwrite;
  assign cnt_wr = wr_acc && (paddr == tcic_pkg::ADDR_CNT_LO);
  assign wr_byte = pwdata[7:0];
  ////////////////////
  // last trigger levels, to spot a change
  always_ff @(posedge clk) begin
    pin_q <= capture_pin;
    cmp_q <= comparator_output;
  end
  // cycles since a trigger moved or software wrote; bounds capture latency
  always_ff @(posedge clk) begin
    if (rst || wr_acc || capture_pin != pin_q || comparator_output != cmp_q) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  ////////////////////
  chk_bottom_zero:
    assert property (count_bottom == (count_value == 16'h0000)) else $error("bottom wrong");
  chk_stop_hold:
    assert property (tick_in == 8'h00 && !cnt_wr |=> $stable(count_value))
    else $error("count moved idle");
  chk_write_wins:
    assert property (cnt_wr |=> count_value[7:0] == $past(wr_byte))
    else $error("count write lost");
  chk_cap_clear:
    assert property (capture_irq_ack && capture_irq && quiet_q > 4'hc |=> !capture_irq)
    else $error("capture flag kept");
  chk_ovf_clear:
    assert property (overflow_irq_ack && overflow_irq && tick_in == 8'h00 |=> !overflow_irq)
    else $error("overflow flag kept");
  chk_ovf_cause:
    assert property ($rose(overflow_irq) |-> $past(tick_in) != 8'h00 || $past(wr_acc))
    else $error("overflow without tick");
  chk_cap_cause:
    assert property ($rose(capture_irq) |-> quiet_q <= 4'hc) else $error("capture uncaused");
  chk_rd_width:
    assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read above byte");
  cov_capture: cover property ($rose(capture_irq));
  cov_write_tick: cover property (cnt_wr && tick_in != 8'h00);
  cov_overflow: cover property ($rose(overflow_irq));
endmodule

bind tcic_timer tcic_timer_properties u_props (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .tick_in(tick_in), .capture_pin(capture_pin),
  .comparator_output(comparator_output), .capture_irq_ack(capture_irq_ack),
  .overflow_irq_ack(overflow_irq_ack), .capture_irq(capture_irq),
  .overflow_irq(overflow_irq), .count_value(count_value), .count_bottom(count_bottom));
`default_nettype wire

/* bench/tcic_cpu_model.sv */
// processor model: apb master doing byte wide register accesses
// assumes any slave latency; waits on pready until the bench gives up
`timescale 1ns/1ps
`default_nettype none
module tcic_cpu_model (
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  logic [7:0] r;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  ////////////////////
  // setup then access; request held until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic w16(input logic [11:0] a, input logic [15:0] v);
    xfer(1'b1, a + 12'h004, v[15:8], r);
    xfer(1'b1, a, v[7:0], r);
  endtask
  task automatic r16(input logic [11:0] a, output logic [15:0] v);
    xfer(1'b0, a, 8'h00, v[7:0]);
    xfer(1'b0, a + 12'h004, 8'h00, v[15:8]);
  endtask
endmodule
`default_nettype wire

/* bench/tcic_timer_tb_top.sv */
// bench for the timer block: directed scenarios over apb
// assumes the cpu model drives the bus and the checker is bound
`timescale 1ns/1ps
`default_nettype none
module tcic_timer_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] tick_in = 8'h00;
  logic pin = 1'b0;
  logic cmp = 1'b0;
  logic cack = 1'b0;
  logic oack = 1'b0;
  logic cirq, oirq, top, bot;
  logic [15:0] cnt, v, u;
  logic [7:0] r;
  int failures = 0;
  int num_checks = 0;
  int n0, n1;
  always #5 clk = ~clk;
  tcic_timer uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tick_in(tick_in), .capture_pin(pin), .comparator_output(cmp), .capture_irq_ack(cack),
    .overflow_irq_ack(oack), .capture_irq(cirq), .overflow_irq(oirq), .count_value(cnt),
    .count_top(top), .count_bottom(bot));
  tcic_cpu_model cpu (.clk(clk), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  ////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic wrap_up;
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    cpu.xfer(1'b1, a, d, r);
  endtask
  task automatic clr;
    wr(tcic_pkg::ADDR_FLAGS, 8'h03);
    // let the clear settle before anyone looks at the flags
    @(negedge clk);
  endtask
  task automatic ld(input logic [15:0] d);
    cpu.w16(tcic_pkg::ADDR_CNT_LO, d);
  endtask
  task automatic cap(output logic [15:0] d);
    cpu.r16(tcic_pkg::ADDR_CAP_LO, d);
  endtask
  // mode, clock select, rising edge, filter
  task automatic ctl(input logic [3:0] m, input logic [2:0] s, input logic e, input logic f);
    wr(tcic_pkg::ADDR_CTRL_A, {6'h00, m[1:0]});
    wr(tcic_pkg::ADDR_CTRL_B, {f, e, 1'b0, m[3:2], s});
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk) tick_in <= 8'h02;
      @(posedge clk) tick_in <= 8'h00;
    end
    @(negedge clk);
  endtask
  // move a trigger, then wait a bounded time for the capture flag
  task automatic trig(input logic c, input logic l, output int n);
    @(posedge clk);
    if (c) cmp <= l;
    else pin <= l;
    n = 0;
    // look at the flag mid-cycle, away from the edge that sets it
    @(negedge clk);
    while (cirq !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask
  ////////////////////
  task automatic t_count;
    wr(tcic_pkg::ADDR_MASK, 8'h03);
    cpu.r16(tcic_pkg::ADDR_CNT_LO, v);
    chk(v, 16'h0000);
    chk1(bot, 1'b1);
    ctl(4'h0, 3'h1, 1'b1, 1'b0);
    tick(5);
    chk(cnt, 16'h0005);
    ctl(4'h0, 3'h0, 1'b1, 1'b0);
    tick(3);
    cpu.r16(tcic_pkg::ADDR_CNT_LO, v);
    chk(v, 16'h0005);
    ctl(4'h0, 3'h1, 1'b1, 1'b0);
    tick_in <= 8'h02;
    ld(16'hfffe);
    tick_in <= 8'h00;
    @(negedge clk);
    chk(cnt, 16'hfffe);
    tick(1);
    chk1(top, 1'b1);
    tick(1);
    chk({cnt[14:0], oirq}, 16'h0001);
    @(posedge clk) oack <= 1'b1;
    @(posedge clk) oack <= 1'b0;
    @(negedge clk);
    chk1(oirq, 1'b0);
    ctl(4'h1, 3'h1, 1'b1, 1'b0);
    ld(16'h00fe);
    tick(1);
    chk({cnt[14:0], top}, 16'h01ff);
    tick(1);
    chk(cnt, 16'h00fe);
    // read across a byte boundary while ticking: the word must not tear
    ctl(4'h0, 3'h1, 1'b1, 1'b0);
    tick_in <= 8'h02;
    ld(16'h00fe);
    cpu.r16(tcic_pkg::ADDR_CNT_LO, v);
    tick_in <= 8'h00;
    chk1(v inside {[16'h00fe:16'h0110]}, 1'b1);
  endtask
  task automatic t_capture;
    ctl(4'h0, 3'h0, 1'b1, 1'b0);
    ld(16'h1234);
    clr;
    trig(1'b0, 1'b1, n0);
    cap(v);
    chk(v, 16'h1234);
    // flip edge after the read, then clear
    ctl(4'h0, 3'h0, 1'b0, 1'b0);
    clr;
    chk1(cirq, 1'b0);
    ld(16'h5678);
    trig(1'b0, 1'b0, n1);
    chk1(cirq, 1'b1);
    ld(16'h9abc);
    repeat (14) @(posedge clk);
    @(posedge clk) cack <= 1'b1;
    @(posedge clk) cack <= 1'b0;
    trig(1'b0, 1'b1, n1);
    chk1(cirq, 1'b0);
    trig(1'b0, 1'b0, n1);
    ld(16'hdef0);
    ctl(4'h0, 3'h0, 1'b1, 1'b0);
    clr;
    trig(1'b0, 1'b1, n1);
    cap(v);
    chk(v, 16'hdef0);
  endtask
  task automatic t_filter;
    ctl(4'h0, 3'h0, 1'b1, 1'b1);
    repeat (12) @(posedge clk);
    clr;
    @(posedge clk) pin <= 1'b0;
    repeat (2) @(posedge clk);
    trig(1'b0, 1'b1, n1);
    chk1(cirq, 1'b0);
    trig(1'b0, 1'b0, n1);
    trig(1'b0, 1'b1, n1);
    chk1(cirq, 1'b1);
    chk1((n1 - n0) == 4, 1'b1);
  endtask
  task automatic t_source;
    wr(tcic_pkg::ADDR_CMP_CS, 8'h01);
    repeat (12) @(posedge clk);
    clr;
    trig(1'b0, 1'b0, n1);
    trig(1'b0, 1'b1, n1);
    chk1(cirq, 1'b0);
    trig(1'b1, 1'b1, n1);
    chk1(cirq, 1'b1);
    wr(tcic_pkg::ADDR_CMP_CS, 8'h00);
  endtask
  task automatic t_top;
    cap(v);
    cpu.w16(tcic_pkg::ADDR_CAP_LO, ~v);
    cap(u);
    chk(u, v);
    ctl(4'hc, 3'h0, 1'b1, 1'b0);
    clr;
    // one upper write serves two loads
    wr(tcic_pkg::ADDR_CNT_HI, 8'h03);
    wr(tcic_pkg::ADDR_CNT_LO, 8'h10);
    wr(tcic_pkg::ADDR_CAP_LO, 8'h20);
    cpu.r16(tcic_pkg::ADDR_CNT_LO, v);
    chk(v, 16'h0310);
    trig(1'b0, 1'b0, n1);
    trig(1'b0, 1'b1, n1);
    cap(v);
    chk(v, 16'h0320);
    chk1(cirq, 1'b0);
    wr(12'h0fc, 8'hff);
    cpu.xfer(1'b0, 12'h0fc, 8'h00, r);
    chk({8'h00, r}, 16'h0000);
    chk1(pslverr, 1'b0);
  endtask
  ////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_count;
    t_capture;
    t_filter;
    t_source;
    t_top;
    wrap_up;
  end
  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk);
    $display("unexpected at %0t: timeout", $time);
    failures++;
    wrap_up;
  end
endmodule
`default_nettype wire
